// File: chg_det_pkg.sv
package chg_det_pkg;

  // Transceiver register map (write / set / clear triplets; event status and debug are single registers)
  localparam logic [5:0] FUNC_CTRL_WR   = 6'h04;
  localparam logic [5:0] FUNC_CTRL_SET  = 6'h05;
  localparam logic [5:0] FUNC_CTRL_CLR  = 6'h06;
  localparam logic [5:0] OTG_CTRL_WR    = 6'h0A;
  localparam logic [5:0] OTG_CTRL_SET   = 6'h0B;
  localparam logic [5:0] OTG_CTRL_CLR   = 6'h0C;
  localparam logic [5:0] EVT_STATUS     = 6'h13;
  localparam logic [5:0] DEBUG_REG      = 6'h15;
  localparam logic [5:0] RID_WR         = 6'h36;
  localparam logic [5:0] RID_SET        = 6'h37;
  localparam logic [5:0] RID_CLR        = 6'h38;
  localparam logic [5:0] IOPM_WR        = 6'h39;
  localparam logic [5:0] IOPM_SET       = 6'h3A;
  localparam logic [5:0] IOPM_CLR       = 6'h3B;

  // Field positions
  localparam int FC_SUSPEND_N   = 6;
  localparam int OTG_ID_PULLUP  = 0;
  localparam int EVT_SESS_VALID = 1;
  localparam int EVT_ID_GND     = 4;
  localparam int RID_DONE       = 3;
  localparam int RID_START      = 4;
  localparam int RID_INT_EN     = 6;
  localparam int IOPM_PU_DP     = 4;
  localparam int IOPM_PU_DM     = 5;
  localparam int LP_INT_BIT     = 3;

  // Reset values
  localparam logic [7:0] FC_RESET     = 8'h41;
  localparam logic [7:0] IOPM_RESET   = 8'h04;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;

  // Values written by the link
  localparam logic [7:0] FC_FS_NODRIVE = 8'h49;
  localparam logic [7:0] FC_NORMAL     = 8'h41;
  localparam logic [7:0] FC_SUSPEND_MASK = 8'h40;
  localparam logic [7:0] PU_DP_MASK    = 8'h10;
  localparam logic [7:0] PU_DM_MASK    = 8'h20;
  localparam logic [7:0] PU_BOTH_MASK  = 8'h30;
  localparam logic [7:0] ID_PU_MASK    = 8'h01;

  // Resistor codes
  localparam logic [2:0] RID_100K  = 3'h2;

  // Line levels
  localparam logic [1:0] LINE_SE0 = 2'h0;
  localparam logic [1:0] LINE_SE1 = 2'h3;
  localparam logic [1:0] VBUS_SESS = 2'h3;

  // Timing
  localparam int CLK_KHZ          = 40000;
  localparam int RID_TIME_US      = 282;
  localparam int RID_CYCLES       = RID_TIME_US * CLK_KHZ / 1000;
  localparam int SETTLE_TIME_US   = 10;
  localparam int SETTLE_CYCLES    = SETTLE_TIME_US * CLK_KHZ / 1000;

  // Controller register map
  localparam logic [1:0] CTL_CMD      = 2'h0;
  localparam logic [1:0] CTL_STATUS   = 2'h1;
  localparam logic [1:0] CTL_INT_STAT = 2'h2;
  localparam logic [1:0] CTL_INT_MASK = 2'h3;
  localparam int CMD_DETECT   = 0;
  localparam int CMD_RID      = 1;
  localparam int CMD_LP       = 2;
  localparam int EV_DET_DONE  = 0;
  localparam int EV_RID_DONE  = 1;
  localparam int EV_VBUS      = 2;

  // Detection result
  localparam logic [1:0] RES_NONE    = 2'h0;
  localparam logic [1:0] RES_CHARGER = 2'h1;
  localparam logic [1:0] RES_HOST    = 2'h2;
  localparam logic [1:0] RES_OTHER   = 2'h3;

endpackage

// File: chg_link_if.sv
`timescale 1ns/1ps
interface chg_link_if;
  logic       req;
  logic       wr;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;
  logic       rxcmd_vld;
  logic [7:0] rxcmd;
  logic       low_power;
  logic [7:0] lp_data;
  logic       exit_lp;

  modport phy_end (
    input  req, wr, addr, wdata, exit_lp,
    output ack, rdata, rxcmd_vld, rxcmd, low_power, lp_data
  );
  modport link_end (
    output req, wr, addr, wdata, exit_lp,
    input  ack, rdata, rxcmd_vld, rxcmd, low_power, lp_data
  );
endinterface

// File: chg_phy_end.sv
`timescale 1ns/1ps
module chg_phy_end #(
  parameter int RID_CYCLES = chg_det_pkg::RID_CYCLES
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  chg_link_if.phy_end     bus,
  input  wire logic       i_session_valid,
  input  wire logic       i_id_grounded,
  input  wire logic       i_line_dplus,
  input  wire logic       i_line_dminus,
  input  wire logic [2:0] i_rid_code,
  output logic            o_charger_pullup_dplus,
  output logic            o_charger_pullup_dminus,
  output logic            o_id_pin_pullup_enable,
  output logic [7:0]      o_function_control
);

  // Write, set or clear, selected by the offset from the triplet base
  function automatic logic [7:0] upd(input logic [7:0] cur, input logic [5:0] a,
                                     input logic [5:0] base, input logic [7:0] w);
    if (a == base) upd = w;
    else if (a == base + 6'h01) upd = cur | w;
    else if (a == base + 6'h02) upd = cur & ~w;
    else upd = cur;
  endfunction

  logic [3:0] s1_q, s2_q;
  logic [7:0] fc_q, otg_q, rid_q, iopm_q, rdata_q, rxcmd_q;
  logic       ack_q, rxv_q, lp_int_q;
  logic [2:0] prev_q;
  logic [$clog2(RID_CYCLES+1)-1:0] cnt_q;

  wire       take     = bus.req && !ack_q;
  wire       wr_take  = take && bus.wr;
  wire       rd_take  = take && !bus.wr;
  wire       sess     = s2_q[0];
  wire       idg      = s2_q[1];
  wire [1:0] line     = s2_q[3:2];
  wire       lp       = !fc_q[chg_det_pkg::FC_SUSPEND_N];
  wire       rid_end  = rid_q[chg_det_pkg::RID_START] && (cnt_q == '0);
  wire       changed  = {sess, line} != prev_q;
  wire [7:0] evt      = {3'h0, idg, 2'h0, sess, 1'b0};
  wire [7:0] rid_wr   = upd(rid_q, bus.addr, chg_det_pkg::RID_WR, bus.wdata);
  wire [7:0] rd_mux   = (bus.addr == chg_det_pkg::FUNC_CTRL_WR) ? fc_q :
                        (bus.addr == chg_det_pkg::OTG_CTRL_WR)  ? otg_q :
                        (bus.addr == chg_det_pkg::EVT_STATUS)   ? evt :
                        (bus.addr == chg_det_pkg::DEBUG_REG)    ? {6'h00, line} :
                        (bus.addr == chg_det_pkg::RID_WR)       ? rid_q :
                        (bus.addr == chg_det_pkg::IOPM_WR)      ? iopm_q :
                        chg_det_pkg::ZERO_BYTE;

  // Pin inputs pass two flops
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= {i_line_dminus, i_line_dplus, i_id_grounded, i_session_valid};
      s2_q <= s1_q;
    end
  end

  logic [2:0] code1_q, code2_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      code1_q <= '0;
      code2_q <= '0;
    end else begin
      code1_q <= i_rid_code;
      code2_q <= code1_q;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fc_q    <= chg_det_pkg::FC_RESET;
      otg_q   <= chg_det_pkg::ZERO_BYTE;
      iopm_q  <= chg_det_pkg::IOPM_RESET;
      ack_q   <= 1'b0;
      rdata_q <= chg_det_pkg::ZERO_BYTE;
    end else begin
      ack_q <= take;
      if (wr_take) begin
        fc_q   <= upd(fc_q, bus.addr, chg_det_pkg::FUNC_CTRL_WR, bus.wdata);
        otg_q  <= upd(otg_q, bus.addr, chg_det_pkg::OTG_CTRL_WR, bus.wdata);
        iopm_q <= upd(iopm_q, bus.addr, chg_det_pkg::IOPM_WR, bus.wdata);
      end else if (lp && bus.exit_lp) begin
        fc_q[chg_det_pkg::FC_SUSPEND_N] <= 1'b1;
      end
      if (rd_take) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Resistor measurement; start clears itself, done clears on a read of the base
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rid_q <= chg_det_pkg::ZERO_BYTE;
      cnt_q <= '0;
    end else begin
      if (wr_take) begin
        rid_q[7:4] <= {1'b0, rid_wr[6], 1'b0, rid_wr[4]};
        rid_q[2:0] <= rid_wr[2:0];
      end
      // Unrelated writes must not stretch the measurement time
      if (wr_take && rid_wr[chg_det_pkg::RID_START] && !rid_q[chg_det_pkg::RID_START]) begin
        cnt_q <= ($clog2(RID_CYCLES+1))'(RID_CYCLES - 1);
      end else if (rid_q[chg_det_pkg::RID_START] && cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end
      if (rid_end) begin
        rid_q[chg_det_pkg::RID_START] <= 1'b0;
        rid_q[2:0]                    <= code2_q;
        rid_q[chg_det_pkg::RID_DONE]  <= 1'b1;
      end else if (rd_take && bus.addr == chg_det_pkg::RID_WR) begin
        rid_q[chg_det_pkg::RID_DONE]  <= 1'b0;
      end
    end
  end

  // Line and vbus reporting: receive command in sync mode, data lines otherwise
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prev_q   <= '0;
      rxv_q    <= 1'b0;
      rxcmd_q  <= chg_det_pkg::ZERO_BYTE;
      lp_int_q <= 1'b0;
    end else begin
      prev_q <= {sess, line};
      rxv_q  <= !lp && changed;
      if (!lp && changed) begin
        rxcmd_q <= {4'h0, sess, sess, line};
      end
      if (!lp) begin
        lp_int_q <= 1'b0;
      end else if (changed || rid_end) begin
        lp_int_q <= 1'b1;
      end
    end
  end

  assign bus.ack                 = ack_q;
  assign bus.rdata               = rdata_q;
  assign bus.rxcmd_vld           = rxv_q;
  assign bus.rxcmd               = rxcmd_q;
  assign bus.low_power           = lp;
  assign bus.lp_data             = lp ? {4'h0, lp_int_q, 1'b0, line} : 8'h00;
  assign o_charger_pullup_dplus  = iopm_q[chg_det_pkg::IOPM_PU_DP];
  assign o_charger_pullup_dminus = iopm_q[chg_det_pkg::IOPM_PU_DM];
  assign o_id_pin_pullup_enable  = otg_q[chg_det_pkg::OTG_ID_PULLUP];
  assign o_function_control      = fc_q;

endmodule // chg_phy_end

// File: chg_link_end.sv
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
// Operation
// - ID measure: ground, pullup, start, done, code
// - 100k code flagged as possible charger
// - Session valid read from receive command
// - Data line 3 carries low-power interrupt
// - Interrupt in low power: exit, read registers; the link acts on it only in S_WAIT_SES
// - Write 49h to function control first
// - Set address 3Ah bit 4 enables pull-up
// - DP and DM pull-ups enabled separately
// - Line state via receive command or debug
// - Data lines 0 and 1 carry line state
// - Sequence: session, tristate, DP, DM, evaluate
// - SE1 with both pull-ups means charger
// - SE0 with both pull-ups means host
// - Three-bit resistor code table
// - Measurement 282us, done cleared by read
// - Start bit clears itself on completion
// - Register 39h write, 3Ah set, 3Bh clear
module chg_link_end #(
  parameter int SETTLE_CYCLES = chg_det_pkg::SETTLE_CYCLES
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  chg_link_if.link_end    bus,
  input  wire logic [1:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic [7:0]      o_rdata,
  output logic            o_irq
);

  typedef enum logic [3:0] {
    S_IDLE     = 4'b0000,
    S_WAIT_SES = 4'b0001,
    S_LP_EXIT  = 4'b0010,
    S_RD_SESS  = 4'b0011,
    S_WR_FC    = 4'b0100,
    S_SET_DP   = 4'b0101,
    S_SET_DM   = 4'b0110,
    S_SETTLE   = 4'b0111,
    S_EVAL     = 4'b1000,
    S_CLR_PU   = 4'b1001,
    S_REST_FC  = 4'b1010,
    S_RID_GND  = 4'b1011,
    S_RID_PU   = 4'b1100,
    S_RID_GO   = 4'b1101,
    S_RID_POLL = 4'b1110,
    S_LP_ENTER = 4'b1111
  } state_e;

  state_e     state_q, state_d;
  logic [1:0] result_q;
  logic [2:0] code_q;
  logic       code_vld_q;
  logic [2:0] ist_q, imask_q;
  logic [7:0] rdata_q;
  logic       sess_q;
  logic [1:0] line_q;
  logic       ev_det, ev_rid, ev_vbus;
  logic [$clog2(SETTLE_CYCLES+1)-1:0] cnt_q;

  // Request table: one register access per access state
  logic       acc;
  logic       acc_wr;
  logic [5:0] acc_addr;
  logic [7:0] acc_data;
  always_comb begin
    acc      = 1'b1;
    acc_wr   = 1'b1;
    acc_addr = chg_det_pkg::EVT_STATUS;
    acc_data = chg_det_pkg::ZERO_BYTE;
    unique case (state_q)
      S_RD_SESS, S_RID_GND: begin
        acc_wr = 1'b0;
      end
      S_WR_FC: begin
        acc_addr = chg_det_pkg::FUNC_CTRL_WR;
        acc_data = chg_det_pkg::FC_FS_NODRIVE;
      end
      S_SET_DP: begin
        acc_addr = chg_det_pkg::IOPM_SET;
        acc_data = chg_det_pkg::PU_DP_MASK;
      end
      S_SET_DM: begin
        acc_addr = chg_det_pkg::IOPM_SET;
        acc_data = chg_det_pkg::PU_DM_MASK;
      end
      S_EVAL: begin
        acc_wr   = 1'b0;
        acc_addr = chg_det_pkg::DEBUG_REG;
      end
      S_CLR_PU: begin
        acc_addr = chg_det_pkg::IOPM_CLR;
        acc_data = chg_det_pkg::PU_BOTH_MASK;
      end
      S_REST_FC: begin
        acc_addr = chg_det_pkg::FUNC_CTRL_WR;
        acc_data = chg_det_pkg::FC_NORMAL;
      end
      S_RID_PU: begin
        acc_addr = chg_det_pkg::OTG_CTRL_SET;
        acc_data = chg_det_pkg::ID_PU_MASK;
      end
      S_RID_GO: begin
        acc_addr = chg_det_pkg::RID_SET;
        acc_data = 8'h10;
      end
      S_RID_POLL: begin
        acc_wr   = 1'b0;
        acc_addr = chg_det_pkg::RID_WR;
      end
      S_LP_ENTER: begin
        acc_addr = chg_det_pkg::FUNC_CTRL_CLR;
        acc_data = chg_det_pkg::FC_SUSPEND_MASK;
      end
      S_IDLE, S_WAIT_SES, S_LP_EXIT, S_SETTLE: begin
        acc    = 1'b0;
        acc_wr = 1'b0;
      end
    endcase
  end

  wire       ack      = bus.ack;
  wire [7:0] rd       = bus.rdata;
  wire       lp       = bus.low_power;
  wire       lp_int   = lp && bus.lp_data[chg_det_pkg::LP_INT_BIT];
  wire       cmd_det  = i_wr && i_addr == chg_det_pkg::CTL_CMD && i_wdata[chg_det_pkg::CMD_DETECT];
  wire       cmd_rid  = i_wr && i_addr == chg_det_pkg::CTL_CMD && i_wdata[chg_det_pkg::CMD_RID];
  wire       cmd_lp   = i_wr && i_addr == chg_det_pkg::CTL_CMD && i_wdata[chg_det_pkg::CMD_LP];
  wire       rx_sess  = bus.rxcmd_vld && bus.rxcmd[3:2] == chg_det_pkg::VBUS_SESS;
  wire [1:0] eval_ln  = rd[1:0];
  wire       busy     = state_q != S_IDLE;
  wire [7:0] status   = {code_q == chg_det_pkg::RID_100K && code_vld_q, code_vld_q, code_q,
                         result_q, busy};

  // Sequencer
  always_comb begin
    state_d = state_q;
    ev_det  = 1'b0;
    ev_rid  = 1'b0;
    unique case (state_q)
      S_IDLE: begin
        if (cmd_det) state_d = S_WAIT_SES;
        else if (cmd_rid) state_d = S_RID_GND;
        else if (cmd_lp) state_d = S_LP_ENTER;
      end
      S_WAIT_SES: begin
        if (lp_int) state_d = S_LP_EXIT;
        else if (!lp && (rx_sess || sess_q)) state_d = S_WR_FC;
      end
      S_LP_EXIT:  if (!lp) state_d = S_RD_SESS;
      S_RD_SESS:  if (ack) state_d = rd[chg_det_pkg::EVT_SESS_VALID] ? S_WR_FC : S_WAIT_SES;
      S_WR_FC:    if (ack) state_d = S_SET_DP;
      S_SET_DP:   if (ack) state_d = S_SET_DM;
      S_SET_DM:   if (ack) state_d = S_SETTLE;
      S_SETTLE:   if (cnt_q == '0) state_d = S_EVAL;
      S_EVAL:     if (ack) state_d = S_CLR_PU;
      S_CLR_PU:   if (ack) state_d = S_REST_FC;
      S_REST_FC: begin
        if (ack) begin
          state_d = S_IDLE;
          ev_det  = 1'b1;
        end
      end
      S_RID_GND:  if (ack && rd[chg_det_pkg::EVT_ID_GND]) state_d = S_RID_PU;
      S_RID_PU:   if (ack) state_d = S_RID_GO;
      S_RID_GO:   if (ack) state_d = S_RID_POLL;
      S_RID_POLL: begin
        if (ack && rd[chg_det_pkg::RID_DONE]) begin
          state_d = S_IDLE;
          ev_rid  = 1'b1;
        end
      end
      S_LP_ENTER: if (ack) state_d = S_IDLE;
    endcase
  end

  assign ev_vbus = rx_sess && !sess_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= S_IDLE;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      if (state_q == S_SET_DM) cnt_q <= ($clog2(SETTLE_CYCLES+1))'(SETTLE_CYCLES);
      else if (cnt_q != '0) cnt_q <= cnt_q - 1'b1;
    end
  end

  // Results and tracked link state
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      result_q   <= chg_det_pkg::RES_NONE;
      code_q     <= '0;
      code_vld_q <= 1'b0;
      sess_q     <= 1'b0;
      line_q     <= chg_det_pkg::LINE_SE0;
    end else begin
      if (bus.rxcmd_vld) begin
        sess_q <= bus.rxcmd[3:2] == chg_det_pkg::VBUS_SESS;
        line_q <= bus.rxcmd[1:0];
      end else if (lp) begin
        line_q <= bus.lp_data[1:0];
      end
      if (state_q == S_RD_SESS && ack) sess_q <= rd[chg_det_pkg::EVT_SESS_VALID];
      if (cmd_det && !busy) result_q <= chg_det_pkg::RES_NONE;
      if (state_q == S_EVAL && ack) begin
        if (eval_ln == chg_det_pkg::LINE_SE1) result_q <= chg_det_pkg::RES_CHARGER;
        else if (eval_ln == chg_det_pkg::LINE_SE0) result_q <= chg_det_pkg::RES_HOST;
        else result_q <= chg_det_pkg::RES_OTHER;
      end
      if (cmd_rid && !busy) code_vld_q <= 1'b0;
      if (ev_rid) begin
        code_q     <= rd[2:0];
        code_vld_q <= 1'b1;
      end
    end
  end

  // Software port, sticky events with set over clear
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ist_q   <= '0;
      imask_q <= '0;
      rdata_q <= chg_det_pkg::ZERO_BYTE;
    end else begin
      ist_q <= (ist_q & ~((i_wr && i_addr == chg_det_pkg::CTL_INT_STAT) ? i_wdata[2:0] : 3'h0))
               | {ev_vbus, ev_rid, ev_det};
      if (i_wr && i_addr == chg_det_pkg::CTL_INT_MASK) imask_q <= i_wdata[2:0];
      if (i_rd) begin
        unique case (i_addr)
          chg_det_pkg::CTL_CMD:      rdata_q <= chg_det_pkg::ZERO_BYTE;
          chg_det_pkg::CTL_STATUS:   rdata_q <= status;
          chg_det_pkg::CTL_INT_STAT: rdata_q <= {5'h00, ist_q};
          chg_det_pkg::CTL_INT_MASK: rdata_q <= {5'h00, imask_q};
        endcase
      end
    end
  end

  assign o_rdata     = rdata_q;
  assign o_irq       = |(ist_q & imask_q);
  assign bus.req     = acc && !ack;
  assign bus.wr      = acc_wr;
  assign bus.addr    = acc_addr;
  assign bus.wdata   = acc_data;
  assign bus.exit_lp = state_q == S_LP_EXIT;

endmodule // chg_link_end

// File: chg_det_chk.sv
`timescale 1ns/1ps
module chg_det_chk #(
  parameter int RID_CYCLES = chg_det_pkg::RID_CYCLES
) (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       req,
  input wire logic       wr,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic [7:0] rdata,
  input wire logic       rxcmd_vld,
  input wire logic [7:0] rxcmd,
  input wire logic       low_power,
  input wire logic [7:0] lp_data,
  input wire logic       exit_lp
);
  logic [15:0] age_q;
  logic [15:0] age_d;
  logic        fs_q;
  logic        fs_d;
  wire         wr_w   = req && wr;
  wire         rid_rd = req && !wr && addr == chg_det_pkg::RID_WR;
  // Write or set of the measure register with the start bit
  wire         start  = wr_w && addr[5:1] == 5'h1B && wdata[chg_det_pkg::RID_START];
  wire         fc_wr  = wr_w && addr == chg_det_pkg::FUNC_CTRL_WR;

  assign age_d = start ? 16'h0000 : age_q + {15'h0000, age_q != 16'hFFFF};
  assign fs_d  = fc_wr ? wdata == chg_det_pkg::FC_FS_NODRIVE : fs_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      age_q <= 16'h0000;
      fs_q  <= 1'h0;
    end else begin
      age_q <= age_d;
      fs_q  <= fs_d;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_pu_dp;
    wr_w && addr == chg_det_pkg::IOPM_SET && wdata == chg_det_pkg::PU_DP_MASK ##1 ack;
  endsequence
  sequence s_pu_dm;
    wr_w && addr == chg_det_pkg::IOPM_SET && wdata == chg_det_pkg::PU_DM_MASK;
  endsequence
  sequence s_pu_off;
    wr_w && addr == chg_det_pkg::IOPM_CLR && wdata == chg_det_pkg::PU_BOTH_MASK ##1 ack;
  endsequence
  sequence s_fc_back;
    fc_wr && wdata == chg_det_pkg::FC_NORMAL;
  endsequence

  property p_ack_pulse;
    req |=> ack ##1 !ack;
  endproperty
  property p_rxcmd_sync;
    rxcmd_vld |-> !low_power && (rxcmd[3:2] == 2'h3 || rxcmd[3:2] == 2'h0);
  endproperty
  property p_lp_fields;
    low_power |-> lp_data[7:4] == 4'h0 && !lp_data[2];
  endproperty
  property p_sync_quiet;
    !low_power && !$past(low_power) |-> lp_data == chg_det_pkg::ZERO_BYTE;
  endproperty
  property p_lp_int_hold;
    low_power && $past(lp_data[3]) && !$past(exit_lp) |-> lp_data[3];
  endproperty
  property p_exit_lp;
    $rose(exit_lp) |-> ##[0:4] !low_power;
  endproperty
  property p_start_clears;
    ack && $past(rid_rd) && rdata[chg_det_pkg::RID_DONE] |-> rdata[7:4] == 4'h0;
  endproperty
  property p_rid_time;
    ack && $past(rid_rd) && rdata[chg_det_pkg::RID_DONE] |-> age_q >= RID_CYCLES - 1;
  endproperty
  property p_fs_first;
    wr_w && addr == chg_det_pkg::IOPM_SET |-> fs_q;
  endproperty
  property p_dp_then_dm;
    s_pu_dp |=> ##[0:2] s_pu_dm;
  endproperty
  property p_restore;
    s_pu_off |=> ##[0:2] s_fc_back;
  endproperty

  a_ack_pulse: assert property (p_ack_pulse)
    else $error("register access answer not a one cycle pulse");
  a_rxcmd_sync: assert property (p_rxcmd_sync)
    else $error("receive command outside sync mode or bad session field");
  a_lp_fields: assert property (p_lp_fields)
    else $error("low power data carries stray bits");
  a_sync_quiet: assert property (p_sync_quiet)
    else $error("low power data not idle in sync mode");
  a_lp_int_hold: assert property (p_lp_int_hold)
    else $error("low power interrupt dropped before exit");
  a_exit_lp: assert property (p_exit_lp)
    else $error("low power not left after exit request");
  a_start_clears: assert property (p_start_clears)
    else $error("measure start still set after done");
  a_rid_time: assert property (p_rid_time)
    else $error("measure done too early");
  a_fs_first: assert property (p_fs_first)
    else $error("pull-up enabled before non-driving mode");
  a_dp_then_dm: assert property (p_dp_then_dm)
    else $error("second pull-up not enabled after first");
  a_restore: assert property (p_restore)
    else $error("function control not restored after pull-ups off");
endmodule // chg_det_chk

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int RID_N = 50;
  typedef struct packed {
    logic       dp;
    logic       dm;
    logic [1:0] res;
  } det_row_s;
  logic       i_clk;
  logic       i_rst;
  logic       session_valid;
  logic       id_grounded;
  logic       line_dp;
  logic       line_dm;
  logic [2:0] rid_code;
  logic [1:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       irq;
  logic       pu_dp;
  logic       pu_dm;
  logic       id_pu;
  logic [7:0] fc;
  logic [7:0] d;
  int         n_mismatch = 0;
  int         check_count = 0;
  int         cyc = 0;
  int         n_dp_only = 0;
  int         n_both = 0;
  int         dp0;
  int         b0;
  int         t0;
  det_row_s   det_rows [4] = '{'{1'h1, 1'h1, chg_det_pkg::RES_CHARGER},
                               '{1'h0, 1'h0, chg_det_pkg::RES_HOST},
                               '{1'h1, 1'h0, chg_det_pkg::RES_OTHER},
                               '{1'h0, 1'h1, chg_det_pkg::RES_OTHER}};
  logic [2:0] codes [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};

  chg_link_if link_bus ();
  chg_phy_end #(.RID_CYCLES(RID_N)) chg_phy_end_inst (
    .i_clk(i_clk), .i_rst(i_rst), .bus(link_bus), .i_session_valid(session_valid),
    .i_id_grounded(id_grounded), .i_line_dplus(line_dp), .i_line_dminus(line_dm),
    .i_rid_code(rid_code), .o_charger_pullup_dplus(pu_dp), .o_charger_pullup_dminus(pu_dm),
    .o_id_pin_pullup_enable(id_pu), .o_function_control(fc));
  chg_link_end #(.SETTLE_CYCLES(4)) chg_link_end_inst (
    .i_clk(i_clk), .i_rst(i_rst), .bus(link_bus), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq));
  chg_det_chk #(.RID_CYCLES(RID_N)) chg_det_chk_inst (
    .i_clk(i_clk), .i_rst(i_rst), .req(link_bus.req), .wr(link_bus.wr),
    .addr(link_bus.addr), .wdata(link_bus.wdata), .ack(link_bus.ack),
    .rdata(link_bus.rdata), .rxcmd_vld(link_bus.rxcmd_vld), .rxcmd(link_bus.rxcmd),
    .low_power(link_bus.low_power), .lp_data(link_bus.lp_data), .exit_lp(link_bus.exit_lp));

  initial begin
    i_clk = 1'h0;
    forever #12.5 i_clk = ~i_clk;
  end

  // Counts cycles with only the first pull-up, and with both in non-driving mode
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (pu_dp && !pu_dm) n_dp_only <= n_dp_only + 1;
    if (pu_dp && pu_dm && fc === chg_det_pkg::FC_FS_NODRIVE) n_both <= n_both + 1;
  end

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
    @(posedge i_clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'h1;
    @(posedge i_clk);
    wr    <= 1'h0;
    #1;
  endtask

  task automatic rd_reg(input logic [1:0] a);
    @(posedge i_clk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge i_clk);
    rd   <= 1'h0;
    #1 d = rdata;
  endtask

  task automatic wait_idle();
    for (int k = 0; k < 3000; k++) begin
      rd_reg(chg_det_pkg::CTL_STATUS);
      if (d[0] === 1'h0) return;
    end
    n_mismatch++;
    report_and_stop();
  endtask

  initial begin
    {i_rst, session_valid, id_grounded, line_dp, line_dm} = 5'h10;
    {rid_code, addr, wdata, wr, rd} = 15'h0000;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'h0;
    @(posedge i_clk);
    #1;
    chk(fc, chg_det_pkg::FC_RESET);
    chk({5'h00, pu_dp, pu_dm, id_pu}, 8'h00);
    chk({7'h00, irq}, 8'h00);
    chk(rdata, 8'h00);
    wr_reg(chg_det_pkg::CTL_INT_MASK, 8'h00);
    foreach (det_rows[k]) begin
      session_valid <= 1'h0;
      line_dp <= det_rows[k].dp;
      line_dm <= det_rows[k].dm;
      repeat (6) @(posedge i_clk);
      wr_reg(chg_det_pkg::CTL_INT_STAT, 8'h07);
      wr_reg(chg_det_pkg::CTL_CMD, 8'h01);
      // Measure request while busy must be dropped
      wr_reg(chg_det_pkg::CTL_CMD, 8'h02);
      repeat (20) @(posedge i_clk);
      rd_reg(chg_det_pkg::CTL_STATUS);
      chk(d & 8'h01, 8'h01);
      chk({6'h00, pu_dp, pu_dm}, 8'h00);
      dp0 = n_dp_only;
      b0 = n_both;
      session_valid <= 1'h1;
      wait_idle();
      chk({6'h00, d[2:1]}, {6'h00, det_rows[k].res});
      chk({7'h00, n_dp_only > dp0}, 8'h01);
      chk({7'h00, n_both > b0}, 8'h01);
      chk({6'h00, pu_dp, pu_dm}, 8'h00);
      chk(fc, chg_det_pkg::FC_NORMAL);
      rd_reg(chg_det_pkg::CTL_INT_STAT);
      chk(d & 8'h07, 8'h05);
    end
    chk({7'h00, irq}, 8'h00);
    wr_reg(chg_det_pkg::CTL_INT_MASK, 8'h01);
    chk({7'h00, irq}, 8'h01);
    wr_reg(chg_det_pkg::CTL_INT_STAT, 8'h01);
    chk({7'h00, irq}, 8'h00);
    wr_reg(chg_det_pkg::CTL_INT_MASK, 8'h04);
    chk({7'h00, irq}, 8'h01);
    wr_reg(chg_det_pkg::CTL_INT_STAT, 8'h04);
    chk({7'h00, irq}, 8'h00);
    rd_reg(chg_det_pkg::CTL_STATUS);
    chk(d & 8'h40, 8'h00);
    foreach (codes[k]) begin
      id_grounded <= 1'h0;
      rid_code <= codes[k];
      repeat (3) @(posedge i_clk);
      t0 = cyc;
      wr_reg(chg_det_pkg::CTL_CMD, 8'h02);
      repeat (10) @(posedge i_clk);
      rd_reg(chg_det_pkg::CTL_STATUS);
      chk(d & 8'h01, 8'h01);
      id_grounded <= 1'h1;
      wait_idle();
      chk({7'h00, cyc - t0 > RID_N}, 8'h01);
      chk(d & 8'hF8, {codes[k] == chg_det_pkg::RID_100K, 1'h1, codes[k], 3'h0});
      chk({7'h00, id_pu}, 8'h01);
    end
    // Low power: the session rise must wake the link through the data-line interrupt
    session_valid <= 1'h0;
    line_dp <= 1'h1;
    line_dm <= 1'h1;
    repeat (6) @(posedge i_clk);
    wr_reg(chg_det_pkg::CTL_INT_STAT, 8'h07);
    wr_reg(chg_det_pkg::CTL_CMD, 8'h04);
    repeat (4) @(posedge i_clk);
    #1;
    chk({7'h00, link_bus.low_power}, 8'h01);
    wr_reg(chg_det_pkg::CTL_CMD, 8'h01);
    session_valid <= 1'h1;
    wait_idle();
    chk({6'h00, d[2:1]}, {6'h00, chg_det_pkg::RES_CHARGER});
    chk({7'h00, link_bus.low_power}, 8'h00);
    rd_reg(chg_det_pkg::CTL_INT_STAT);
    chk(d & 8'h07, 8'h01);
    report_and_stop();
  end
endmodule // tb_top
